/* hw/sra_map.vh */
`ifndef SRA_MAP_VH
`define SRA_MAP_VH

// apb register offsets
`define SRA_OFF_CTRL 8'h00
`define SRA_OFF_WDATA 8'h04
`define SRA_OFF_RDATA 8'h08
`define SRA_OFF_STATUS 8'h0c

// ctrl fields
`define SRA_CTRL_ADDR_LSB 0
`define SRA_CTRL_DIR_BIT 8
`define SRA_CTRL_CNT_LSB 16
`define SRA_CTRL_GO_BIT 31

// status fields
`define SRA_ST_BUSY_BIT 0
`define SRA_ST_WDV_BIT 1
`define SRA_ST_RDV_BIT 2
`define SRA_ST_NACK_BIT 3

// device register numbers and word layout
`define SRA_DEV_REG_STORE 5'h1c
`define SRA_DEV_REG_DIAG 5'h1e
`define SRA_DEV_REG_LOCK 5'h0b
`define SRA_DEV_FAULT_MSB 15
`define SRA_DEV_FAULT_LSB 10

// timing
`define SRA_CLK_PERIOD_NS 25
`define SRA_SCL_PERIOD_NS 10000
`define SRA_SAVE_TIME_MS 700
`define SRA_UNLOCK_TIME_S 15
`define SRA_CNT_W 8
// quarter of one scl bit, less one, in reference clocks
`define SRA_QTR_LAST 8'h63

// reset values
`define SRA_RST_SCL 1'b1
`define SRA_RST_WORD 16'h0000

`endif

/* hw/sra_sync.v */
`timescale 1ns/10ps
module sra_sync #(
  parameter W = 1,
  parameter RST = 1'b1
) (
  // clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // data
  input wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

reg [W-1:0] meta_q;
reg [W-1:0] sync_q;

// first stage feeds only the second stage
always @(posedge i_ref_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    meta_q <= {W{RST}};
    sync_q <= {W{RST}};
  end else begin
    meta_q <= i_async;
    sync_q <= meta_q;
  end
end

assign o_sync = sync_q;

endmodule

/* hw/sra_host.v */
`timescale 1ns/10ps
`include "sra_map.vh"
module sra_host (
  // clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // apb slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // two-wire link
  output wire o_scl,
  input wire i_sda,
  output wire o_sda,
  output wire o_sda_oen
);

////////////////////////////////////////////////////////////////////////////////
// constants

// sized to the counter so no bits are dropped
localparam [`SRA_CNT_W-1:0] QTR_LAST = `SRA_QTR_LAST;

localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_START = 3'h1;
localparam [2:0] S_BIT = 3'h2;
localparam [2:0] S_HOLD = 3'h3;
localparam [2:0] S_STOP = 3'h4;

////////////////////////////////////////////////////////////////////////////////
// declarations

reg [2:0] st_q, st_d;
reg [1:0] ph_q, ph_d;
reg [`SRA_CNT_W-1:0] cnt_q;
reg [3:0] bit_q, bit_d;
reg [7:0] sh_q, sh_d;
reg addr_ph_q, addr_ph_d;
reg hi_q, hi_d;
reg [4:0] left_q, left_d;
reg dir_q, dir_d;
reg [7:0] rxhi_q, rxhi_d;
reg [15:0] wword_q, wword_d;
reg scl_q, scl_d;
reg sdal_q, sdal_d;
reg ackbad_q, ackbad_d;
reg wd_take;
reg rd_set;
reg nack_set;

reg [4:0] ctl_addr_q;
reg ctl_dir_q;
reg [4:0] ctl_cnt_q;
reg wdv_q;
reg [15:0] wdat_q;
reg rdv_q;
reg [15:0] rdat_q;
reg nack_q;
reg [31:0] prdata_q;
reg pready_q;
reg pslverr_q;
reg [31:0] rd_mux;
reg addr_ok;

wire sda_s;
wire tick;
wire tx;
wire busy;
wire acc;
wire wr_acc;
wire rd_acc;
wire go;
wire wd_set;
wire rd_clr;
wire nack_clr;

////////////////////////////////////////////////////////////////////////////////
// link input

// sda is asynchronous to our clock
sra_sync #(
  .W(1),
  .RST(1'b1)
) u_sda_sync (
  .i_ref_clk(i_ref_clk),
  .i_resetn(i_resetn),
  .i_async(i_sda),
  .o_sync(sda_s)
);

////////////////////////////////////////////////////////////////////////////////
// apb decode

assign acc = i_psel & i_penable & pready_q;
assign wr_acc = acc & i_pwrite;
assign rd_acc = acc & ~i_pwrite;
assign busy = (st_q != S_IDLE);
// new commands while busy are dropped
assign go = wr_acc & (i_paddr == `SRA_OFF_CTRL) & i_pwdata[`SRA_CTRL_GO_BIT] & ~busy;
assign wd_set = wr_acc & (i_paddr == `SRA_OFF_WDATA) & ~wdv_q;
assign rd_clr = rd_acc & (i_paddr == `SRA_OFF_RDATA);
assign nack_clr = wr_acc & (i_paddr == `SRA_OFF_STATUS) & i_pwdata[`SRA_ST_NACK_BIT];

always @* begin
  rd_mux = 32'h00000000;
  addr_ok = 1'b1;
  case (i_paddr)
    `SRA_OFF_CTRL: begin
      rd_mux[`SRA_CTRL_ADDR_LSB +: 5] = ctl_addr_q;
      rd_mux[`SRA_CTRL_DIR_BIT] = ctl_dir_q;
      rd_mux[`SRA_CTRL_CNT_LSB +: 5] = ctl_cnt_q;
      rd_mux[`SRA_CTRL_GO_BIT] = busy;
    end
    `SRA_OFF_WDATA: rd_mux[15:0] = wdat_q;
    `SRA_OFF_RDATA: rd_mux[15:0] = rdat_q;
    `SRA_OFF_STATUS: begin
      rd_mux[`SRA_ST_BUSY_BIT] = busy;
      rd_mux[`SRA_ST_WDV_BIT] = wdv_q;
      rd_mux[`SRA_ST_RDV_BIT] = rdv_q;
      rd_mux[`SRA_ST_NACK_BIT] = nack_q;
    end
    default: addr_ok = 1'b0;
  endcase
end

// no wait state; read data is sampled into flops in the setup cycle
always @(posedge i_ref_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    prdata_q <= 32'h00000000;
    pready_q <= 1'b0;
    pslverr_q <= 1'b0;
  end else begin
    pready_q <= i_psel & ~i_penable;
    if (i_psel & ~i_penable) begin
      prdata_q <= i_pwrite ? 32'h00000000 : rd_mux;
      pslverr_q <= ~addr_ok;
    end else begin
      pslverr_q <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// software registers

always @(posedge i_ref_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    ctl_addr_q <= 5'h00;
    ctl_dir_q <= 1'b0;
    ctl_cnt_q <= 5'h00;
    wdv_q <= 1'b0;
    wdat_q <= `SRA_RST_WORD;
    rdv_q <= 1'b0;
    rdat_q <= `SRA_RST_WORD;
    nack_q <= 1'b0;
  end else begin
    if (go) begin
      ctl_addr_q <= i_pwdata[`SRA_CTRL_ADDR_LSB +: 5];
      ctl_dir_q <= i_pwdata[`SRA_CTRL_DIR_BIT];
      ctl_cnt_q <= i_pwdata[`SRA_CTRL_CNT_LSB +: 5];
    end
    if (wd_set) begin
      wdat_q <= i_pwdata[15:0];
    end
    wdv_q <= wd_set | (wdv_q & ~wd_take);
    if (rd_set) begin
      rdat_q <= {rxhi_q, sh_q};
    end
    // set beats clear on the same edge
    rdv_q <= rd_set | (rdv_q & ~rd_clr);
    nack_q <= nack_set | (nack_q & ~nack_clr);
  end
end

////////////////////////////////////////////////////////////////////////////////
// quarter-bit timebase

assign tick = (cnt_q == QTR_LAST);

always @(posedge i_ref_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    cnt_q <= {`SRA_CNT_W{1'b0}};
  end else if (st_q == S_IDLE || tick) begin
    cnt_q <= {`SRA_CNT_W{1'b0}};
  end else begin
    cnt_q <= cnt_q + 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////////
// link sequencer

// address and write bytes are ours to send
assign tx = addr_ph_q | ~dir_q;

always @* begin
  st_d = st_q;
  ph_d = ph_q;
  bit_d = bit_q;
  sh_d = sh_q;
  addr_ph_d = addr_ph_q;
  hi_d = hi_q;
  left_d = left_q;
  dir_d = dir_q;
  rxhi_d = rxhi_q;
  wword_d = wword_q;
  scl_d = scl_q;
  sdal_d = sdal_q;
  ackbad_d = ackbad_q;
  wd_take = 1'b0;
  rd_set = 1'b0;
  nack_set = 1'b0;
  case (st_q)
    S_IDLE: begin
      scl_d = 1'b1;
      sdal_d = 1'b0;
      if (go) begin
        st_d = S_START;
        ph_d = 2'h0;
        sh_d = {2'b00, i_pwdata[`SRA_CTRL_ADDR_LSB +: 5], i_pwdata[`SRA_CTRL_DIR_BIT]};
        addr_ph_d = 1'b1;
        dir_d = i_pwdata[`SRA_CTRL_DIR_BIT];
        left_d = i_pwdata[`SRA_CTRL_CNT_LSB +: 5];
      end
    end
    S_START: begin
      if (tick) begin
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: sdal_d = 1'b1;
          2'h1: scl_d = 1'b0;
          2'h2: begin
            st_d = S_BIT;
            ph_d = 2'h0;
            bit_d = 4'h0;
          end
          default: st_d = S_BIT;
        endcase
      end
    end
    S_BIT: begin
      if (tick) begin
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: begin
            // data moves only with scl low
            if (bit_q != 4'h8) begin
              sdal_d = tx & ~sh_q[7];
            end else if (tx) begin
              sdal_d = 1'b0;
            end else begin
              // last low byte of a burst is refused to end it
              sdal_d = ~(~hi_q && left_q == 5'h00);
            end
          end
          2'h1: scl_d = 1'b1;
          2'h2: begin
            if (bit_q != 4'h8) begin
              sh_d = {sh_q[6:0], sda_s};
            end else begin
              ackbad_d = sda_s;
            end
          end
          default: begin
            scl_d = 1'b0;
            if (bit_q != 4'h8) begin
              bit_d = bit_q + 4'h1;
            end else begin
              bit_d = 4'h0;
              if (tx & ackbad_q) begin
                nack_set = 1'b1;
                st_d = S_STOP;
              end else if (addr_ph_q) begin
                addr_ph_d = 1'b0;
                st_d = S_HOLD;
              end else if (hi_q) begin
                hi_d = 1'b0;
                if (dir_q) begin
                  rxhi_d = sh_q;
                end else begin
                  sh_d = wword_q[7:0];
                end
              end else begin
                rd_set = dir_q;
                if (left_q == 5'h00) begin
                  st_d = S_STOP;
                end else begin
                  left_d = left_q - 5'h01;
                  st_d = S_HOLD;
                end
              end
            end
          end
        endcase
      end
    end
    S_HOLD: begin
      // scl stays low until software has room or data
      if (tick && (dir_q ? ~rdv_q : wdv_q)) begin
        st_d = S_BIT;
        ph_d = 2'h0;
        bit_d = 4'h0;
        hi_d = 1'b1;
        if (dir_q) begin
          sh_d = 8'hff;
        end else begin
          sh_d = wdat_q[15:8];
          // whole words only; save and unlock waits are left to software
          wword_d = wdat_q;
          wd_take = 1'b1;
        end
      end
    end
    S_STOP: begin
      if (tick) begin
        ph_d = ph_q + 2'h1;
        case (ph_q)
          2'h0: sdal_d = 1'b1;
          2'h1: scl_d = 1'b1;
          2'h2: sdal_d = 1'b0;
          default: st_d = S_IDLE;
        endcase
      end
    end
    default: st_d = S_IDLE;
  endcase
end

always @(posedge i_ref_clk or negedge i_resetn) begin
  if (!i_resetn) begin
    st_q <= S_IDLE;
    ph_q <= 2'h0;
    bit_q <= 4'h0;
    sh_q <= 8'h00;
    addr_ph_q <= 1'b0;
    hi_q <= 1'b0;
    left_q <= 5'h00;
    dir_q <= 1'b0;
    rxhi_q <= 8'h00;
    wword_q <= `SRA_RST_WORD;
    scl_q <= `SRA_RST_SCL;
    sdal_q <= 1'b0;
    ackbad_q <= 1'b0;
  end else begin
    st_q <= st_d;
    ph_q <= ph_d;
    bit_q <= bit_d;
    sh_q <= sh_d;
    addr_ph_q <= addr_ph_d;
    hi_q <= hi_d;
    left_q <= left_d;
    dir_q <= dir_d;
    rxhi_q <= rxhi_d;
    wword_q <= wword_d;
    scl_q <= scl_d;
    sdal_q <= sdal_d;
    ackbad_q <= ackbad_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign o_prdata = prdata_q;
assign o_pready = pready_q;
assign o_pslverr = pslverr_q;
assign o_scl = scl_q;
// open drain: only ever pulls low
assign o_sda = 1'b0;
assign o_sda_oen = ~sdal_q;

endmodule

/* tb/sra_host_props.sv */
`timescale 1ns/10ps
module sra_host_chk (
  // clock and reset
  input wire i_ref_clk,
  input wire i_resetn,
  // apb
  input wire i_psel,
  input wire i_penable,
  input wire [7:0] i_paddr,
  input wire o_pready,
  input wire o_pslverr,
  // link
  input wire o_scl,
  input wire o_sda_oen
);
  logic scl_q, oen_q, rd;
  logic [3:0] bits;
  logic [7:0] nb;
  wire rise = o_scl && !scl_q;
  // bit and byte position, restarted by each start
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      scl_q <= 1'b1;
      oen_q <= 1'b1;
      rd <= 1'b0;
      bits <= 4'h0;
      nb <= 8'h00;
    end else begin
      scl_q <= o_scl;
      oen_q <= o_sda_oen;
      if (scl_q && o_scl && oen_q && !o_sda_oen) begin
        bits <= 4'h0;
        nb <= 8'h00;
      end else if (rise) begin
        bits <= (bits == 4'h9) ? 4'h1 : bits + 4'h1;
        if (bits == 4'h9) nb <= nb + 8'h01;
        if (bits == 4'h7 && nb == 8'h00) rd <= o_sda_oen;
      end
    end
  end
  ////////////////////////
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  a_ready_pulse: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
    else $error("pready not a one cycle access answer");
  a_err_unmapped: assert property (i_psel && !i_penable && i_paddr > 8'h0c |=> o_pslverr)
    else $error("unmapped address without pslverr");
  a_start_clocks: assert property (
    scl_q && o_scl && oen_q && !o_sda_oen |-> ##[1:150] !o_scl)
    else $error("start not followed by clocking");
  a_stop_idle: assert property (
    scl_q && o_scl && !oen_q && o_sda_oen |-> o_scl [*8])
    else $error("clock moved after stop");
  a_sda_hold_high: assert property (rise |-> $stable(o_sda_oen) [*8])
    else $error("data changed while clock high");
  a_addr_top_zero: assert property (rise && nb == 8'h00 && bits < 4'h2 |-> !o_sda_oen)
    else $error("top address bits not zero");
  a_ack_release: assert property (
    rise && bits == 4'h8 && (nb == 8'h00 || !rd) |-> o_sda_oen)
    else $error("data held in acknowledge clock");
  a_read_release: assert property (rise && bits < 4'h8 && nb > 8'h00 && rd |-> o_sda_oen)
    else $error("data held during read byte");
  a_read_ack: assert property (rise && bits == 4'h8 && nb[0] && rd |-> !o_sda_oen)
    else $error("upper read byte not acknowledged");
endmodule

bind sra_host sra_host_chk chk (
  .i_ref_clk(i_ref_clk),
  .i_resetn(i_resetn),
  .i_psel(i_psel),
  .i_penable(i_penable),
  .i_paddr(i_paddr),
  .o_pready(o_pready),
  .o_pslverr(o_pslverr),
  .o_scl(o_scl),
  .o_sda_oen(o_sda_oen)
);

/* tb/sra_dev_model.sv */
`timescale 1ns/10ps
module sra_dev_model #(
  parameter logic [5:0] FLT = 6'h05,
  // stored lock code; nonzero starts the model locked
  parameter logic [9:0] LOCK = 10'h000,
  // position of the critical flag among the fault bits
  parameter int CRIT = 5,
  parameter bit SAVE_OK = 1'b1
) (
  input wire i_scl,
  input wire i_sda,
  output logic o_pull
);
  logic [15:0] mem [32];
  logic [7:0] sh, whi;
  logic [3:0] bitc;
  logic [1:0] ph;
  logic [4:0] ptr;
  logic [9:0] cnt;
  logic [5:0] flt;
  logic rd, hi, done, eeprom_store_trigger, wear, locked;
  function automatic logic [15:0] word(input logic [4:0] p);
    if (p == 5'd30) return {flt, 10'h000};
    if (p == 5'd28) return {flt, cnt};
    // fixed scramble stands in for random data; spares the product id bits
    if (locked) return {flt, mem[p][9:0] ^ ((p == 5'd15) ? 10'h30f : 10'h3ff)};
    return {flt, mem[p][9:0]};
  endfunction
  initial begin
    for (int i = 0; i < 32; i++) mem[i] = 16'(i);
    mem[11] = {6'h00, LOCK};
    locked = (LOCK != 10'h000);
    wear = 1'b0;
    cnt = 10'h000;
    flt = FLT;
    eeprom_store_trigger = 1'b0;
    ph = 2'd3;
    bitc = 4'h0;
    o_pull = 1'b0;
  end
  ////////////////////////
  // partial words are dropped since writes land only on the low byte
  always @(negedge i_sda) if (i_scl) begin
    ph = 2'd0;
    bitc = 4'h0;
    hi = 1'b1;
    done = 1'b0;
  end
  always @(posedge i_sda) if (i_scl) ph = 2'd3;
  always @(posedge i_scl) begin
    if (bitc == 4'h8) begin
      bitc = 4'h0;
      if (ph == 2'd1) ph = 2'd2;
      else if (ph == 2'd2 && rd) begin
        done = done | i_sda;
        hi = !hi;
        if (hi) ptr = ptr + 5'd1;
      end
    end else begin
      sh = {sh[6:0], i_sda};
      bitc = bitc + 4'h1;
      if (bitc == 4'h8 && ph == 2'd0) begin
        ptr = sh[5:1];
        rd = sh[0];
        ph = 2'd1;
      end else if (bitc == 4'h8 && ph == 2'd2 && !rd) begin
        if (hi) whi = sh;
        else begin
          // locked: only the lock code register takes a word
          if (!locked || ptr == 5'd11) begin
            if (ptr == 5'd28) begin
              // save is instant here, so no motor command can land during it
              if (eeprom_store_trigger && !whi[1]) begin
                if (!SAVE_OK) flt[CRIT] = 1'b1;
                else begin
                  if (cnt != 10'h3ff) cnt = cnt + 10'd1;
                  else if (!wear) begin
                    wear = 1'b1;
                    cnt = 10'h000;
                  end
                  flt = 6'h00;
                end
              end
              eeprom_store_trigger = whi[1];
            end
            mem[ptr] = {6'h00, whi[1:0], sh};
          end
          ptr = ptr + 5'd1;
        end
        hi = !hi;
      end
    end
  end
  always @(negedge i_scl) begin
    logic [15:0] w;
    w = word(ptr);
    if (bitc == 4'h8 && (ph == 2'd1 || (ph == 2'd2 && !rd))) o_pull = 1'b1;
    else if (ph == 2'd2 && rd && !done && bitc < 4'h8)
      o_pull = !(hi ? w[15-bitc] : w[7-bitc]);
    else o_pull = 1'b0;
  end
endmodule

/* tb/sra_host_test.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s expected %h seen %h", n, e, g); end end
module sra_host_test;
  logic i_ref_clk = 0, i_resetn = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [7:0] i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0, rd;
  logic er;
  wire [31:0] o_prdata;
  wire o_pready, o_pslverr, o_scl, o_sda, o_sda_oen, pull;
  // pull-up: high unless someone pulls low
  wire sda = (o_sda_oen || o_sda) && !pull;
  int checks = 0, miscompares = 0, cycles = 0;
  always #12.5 i_ref_clk = ~i_ref_clk;
  sra_host dut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_scl(o_scl),
    .i_sda(sda), .o_sda(o_sda), .o_sda_oen(o_sda_oen));
  sra_dev_model dev (.i_scl(o_scl), .i_sda(sda), .o_pull(pull));
  ////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_psel <= 1;
    i_penable <= 0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1;
    do @(posedge i_ref_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
  endtask
  // a hang here is cut by the cycle ceiling
  task automatic poll(input int b, input logic v);
    do apb(0, 8'h0c, 0); while (rd[b] !== v);
  endtask
  task automatic wr_word(input logic [4:0] r, input logic [15:0] d);
    apb(1, 8'h04, {16'h0, d});
    apb(1, 8'h00, 32'h8000_0000 | r);
    poll(0, 0);
  endtask
  task automatic rd_words(input logic [4:0] r, input int n, input logic [15:0] e0, e1);
    apb(1, 8'h00, 32'h8000_0100 | ((n - 1) << 16) | r);
    for (int k = 0; k < n; k++) begin
      poll(2, 1);
      apb(0, 8'h08, 0);
      `CHK("read word", k ? e1 : e0, rd[15:0])
    end
    poll(0, 0);
  endtask
  ////////////////////////
  task automatic t_apb;
    apb(0, 8'h0c, 0);
    `CHK("status", 32'h0, rd)
    `CHK("status pslverr", 1'b0, er)
    apb(0, 8'h00, 0);
    `CHK("ctrl", 32'h0, rd)
    apb(0, 8'h10, 0);
    `CHK("pslverr", 1'b1, er)
  endtask
  task automatic t_burst;
    rd_words(5'd27, 2, 16'h141b, 16'h1400);
    apb(0, 8'h00, 0);
    `CHK("ctrl fields", 32'h0001_011b, rd)
  endtask
  task automatic t_save;
    rd_words(5'd28, 1, 16'h1400, 16'h0000);
    wr_word(5'd28, 16'hfe00);
    `CHK("stored word", 16'h0200, dev.mem[28])
    wr_word(5'd28, 16'h0000);
    rd_words(5'd28, 1, 16'h0001, 16'h0000);
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_resetn <= 1;
    t_apb();
    t_burst();
    t_save();
    give_verdict();
  end
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      give_verdict();
    end
  end
endmodule
